// ---- sim/ordf_top_props.sv ----
`timescale 1ns/1ps
module ordf_top_chk #(
  parameter int NREL = 4
) (
  input wire logic            clk,
  input wire logic            rst,
  input wire logic            sup_in,
  input wire logic            sup_out,
  input wire logic [NREL-1:0] relay_out,
  input wire logic            s_axi_awready,
  input wire logic            s_axi_wready,
  input wire logic            s_axi_bvalid,
  input wire logic            s_axi_bready,
  input wire logic [1:0]      s_axi_bresp,
  input wire logic            s_axi_arvalid,
  input wire logic            s_axi_arready,
  input wire logic            s_axi_rvalid,
  input wire logic            s_axi_rready,
  input wire logic [31:0]     s_axi_rdata
);
  // Age since reset, so the sync chain holds no reset-time values
  logic [2:0] age_q;
  logic [2:0] age_d;
  always_comb age_d = rst ? 3'h0 : (age_q[2] ? age_q : age_q + 3'h1);
  always_ff @(posedge clk) age_q <= age_d;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_sup; age_q[2] |-> sup_out == $past(sup_in, 3); endproperty
  a_sup: assert property (p_sup) else $error("sup out lag");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("bvalid dropped");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("rvalid dropped");
  property p_rlat; s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid && s_axi_arready;
  endproperty
  a_rlat: assert property (p_rlat) else $error("read late");
  property p_arpulse; s_axi_arready |=> !s_axi_arready; endproperty
  a_arpulse: assert property (p_arpulse) else $error("arready long");
  property p_awpulse; s_axi_awready |=> !s_axi_awready; endproperty
  a_awpulse: assert property (p_awpulse) else $error("awready long");
  property p_wpulse; s_axi_wready |=> !s_axi_wready; endproperty
  a_wpulse: assert property (p_wpulse) else $error("wready long");
  property p_blat; s_axi_awready && s_axi_wready |-> ##[1:2] s_axi_bvalid; endproperty
  a_blat: assert property (p_blat) else $error("bvalid late");
endmodule : ordf_top_chk
bind ordf_top ordf_top_chk #(.NREL(NREL)) u_chk (.*);

// ---- sim/ordf_top_tb.sv ----
`timescale 1ns/1ps
`include "ordf_regs.svh"
module ordf_top_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [27:0] sig_in = '0;
  logic        sup_in = 1'b0;
  logic [3:0]  relay_out;
  logic        sup_out;
  logic [11:0] s_axi_awaddr = '0;
  logic [11:0] s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [31:0] s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  s_axi_bresp;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready;
  logic        s_axi_wready;
  logic        s_axi_bvalid;
  logic        s_axi_arready;
  logic        s_axi_rvalid;
  logic [31:0] rv;
  logic [1:0]  rs;
  int          miscompares = 0;
  int          checks = 0;
  // Short tick keeps centisecond timers to tens of cycles
  ordf_top #(.TICK_CYC(10)) dut (.*);
  always #5 clk = ~clk;
  task automatic wrap_up;
    if (miscompares == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up
  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask : ck
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask : cyc
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    if (n == 50) begin
      miscompares++;
      $display("ERROR %0t write timeout", $time);
    end
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    int n = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    if (n == 50) begin
      miscompares++;
      $display("ERROR %0t read timeout", $time);
    end
    rv = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    rd(a);
    ck(rv, e);
    ck(rs, 32'h0);
  endtask : rc
  // Inputs need three cycles to reach the relays
  task automatic rl(input logic [3:0] e);
    cyc(6);
    ck(relay_out, e);
  endtask : rl
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rc(`ORDF_CTRL_OFF, 32'h0);
    rc(`ORDF_TDIS_OFF, 32'h3);
    rc(`ORDF_TFRC_OFF, 32'h3);
    rc(`ORDF_INV_OFF, 32'h0);
    rd(12'h020);
    ck(rs, 32'h2);
    wr(12'h020, 32'h1);
    ck(rs, 32'h2);
    sig_in <= 28'h40;
    rl(4'h1);
    wr(`ORDF_INV_OFF, 32'h40);
    rl(4'h0);
    wr(`ORDF_INV_OFF, 32'h0);
    wr(`ORDF_CMD_OFF, 32'h1);
    rl(4'h1);
    wr(`ORDF_CTRL_OFF, 32'h1);
    rl(4'h1);
    wr(`ORDF_CMD_OFF, 32'h1);
    rl(4'h0);
    rc(`ORDF_STAT_OFF, 32'h400);
    sup_in <= 1'b1;
    cyc(4);
    ck(sup_out, 32'h1);
    wr(`ORDF_CMD_OFF, 32'h4);
    rl(4'h0);
    rc(`ORDF_STAT_OFF, 32'hc00);
    cyc(300);
    rl(4'h0);
    wr(`ORDF_CMD_OFF, 32'h2);
    rl(4'h1);
    wr(`ORDF_TDIS_OFF, 32'h2);
    wr(`ORDF_CTRL_OFF, 32'h3);
    wr(`ORDF_CMD_OFF, 32'h1);
    rl(4'h0);
    cyc(30);
    rl(4'h1);
    wr(`ORDF_CTRL_OFF, 32'h0);
    wr(`ORDF_CMD_OFF, 32'h8);
    rl(4'h0);
    wr(`ORDF_CMD_OFF, 32'h4);
    rl(4'hf);
    sig_in <= 28'h0;
    cyc(300);
    rl(4'hf);
    wr(`ORDF_CMD_OFF, 32'h10);
    rl(4'h0);
    wr(`ORDF_CTRL_OFF, 32'h4);
    wr(`ORDF_TFRC_OFF, 32'h2);
    wr(`ORDF_CMD_OFF, 32'h4);
    rl(4'hf);
    cyc(30);
    rl(4'h0);
    wrap_up();
  end
  initial begin
    repeat (4000) @(posedge clk);
    miscompares++;
    $display("ERROR %0t watchdog expired", $time);
    wrap_up();
  end
endmodule : ordf_top_tb

// ---- src/ordf_axil.sv ----
`timescale 1ns/1ps
`include "ordf_regs.svh"
module ordf_axil
  import ordf_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             wr_en,
  output logic [11:0]      wr_addr,
  output logic [31:0]      wr_data,
  output logic [3:0]       wr_strb,
  output logic [11:0]      rd_addr,
  input  wire logic [31:0] rd_data,
  input  wire logic        rd_ok,
  input  wire logic        wr_ok
);
  logic aw_q, aw_d, w_q, w_d, b_d, r_d;
  logic [11:0] awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rdat_d;
  logic [3:0]  ws_q, ws_d;
  logic [1:0]  br_d, rr_d;
  assign wr_en   = aw_q && w_q && !s_axi_bvalid;
  assign wr_addr = awa_q;
  assign wr_data = wd_q;
  assign wr_strb = ws_q;
  assign rd_addr = s_axi_araddr;
  always_comb begin
    aw_d = aw_q;
    w_d = w_q;
    awa_d = awa_q;
    wd_d = wd_q;
    ws_d = ws_q;
    b_d = s_axi_bvalid;
    br_d = s_axi_bresp;
    r_d = s_axi_rvalid;
    rr_d = s_axi_rresp;
    rdat_d = s_axi_rdata;
    if (s_axi_awvalid && !aw_q) begin
      aw_d = 1'b1;
      awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_q) begin
      w_d = 1'b1;
      wd_d = s_axi_wdata;
      ws_d = s_axi_wstrb;
    end
    if (wr_en) begin
      b_d = 1'b1;
      br_d = wr_ok ? 2'b00 : 2'b10;
      aw_d = 1'b0;
      w_d = 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      b_d = 1'b0;
    end
    if (s_axi_arvalid && !s_axi_rvalid) begin
      r_d = 1'b1;
      rdat_d = rd_ok ? rd_data : 32'h0;
      rr_d = rd_ok ? 2'b00 : 2'b10;
    end else if (s_axi_rvalid && s_axi_rready) begin
      r_d = 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= 12'h0;
      wd_q <= 32'h0;
      ws_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'b00;
      s_axi_rdata <= 32'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      aw_q <= aw_d;
      w_q <= w_d;
      awa_q <= awa_d;
      wd_q <= wd_d;
      ws_q <= ws_d;
      s_axi_bvalid <= b_d;
      s_axi_bresp <= br_d;
      s_axi_rvalid <= r_d;
      s_axi_rresp <= rr_d;
      s_axi_rdata <= rdat_d;
      s_axi_awready <= s_axi_awvalid && !aw_q && !s_axi_awready;
      s_axi_wready <= s_axi_wvalid && !w_q && !s_axi_wready;
      s_axi_arready <= s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
    end
  end
endmodule : ordf_axil

// ---- src/ordf_pkg.sv ----
package ordf_pkg;
  typedef enum logic [1:0] {ORDF_NORMAL, ORDF_FRC_ON, ORDF_FRC_OFF} ordf_force_e;
  typedef logic [15:0] ordf_cs_t;
endpackage : ordf_pkg

// ---- src/ordf_regs.svh ----
`ifndef ORDF_REGS_SVH
`define ORDF_REGS_SVH
`define ORDF_CTRL_OFF      12'h000
`define ORDF_CMD_OFF       12'h004
`define ORDF_TDIS_OFF      12'h008
`define ORDF_TFRC_OFF      12'h00c
`define ORDF_INV_OFF       12'h010
`define ORDF_STAT_OFF      12'h014
`define ORDF_CTRL_DIS_EN   0
`define ORDF_CTRL_DIS_TMO  1
`define ORDF_CTRL_FRC_TMO  2
`define ORDF_CMD_DISARM    0
`define ORDF_CMD_REARM     1
`define ORDF_CMD_FRC_ON    2
`define ORDF_CMD_FRC_OFF   3
`define ORDF_CMD_FRC_CLR   4
`define ORDF_CTRL_RST      32'h0000_0000
`define ORDF_INV_RST       32'h0000_0000
`define ORDF_TICK_NS       10000000
`define ORDF_CLK_NS        10
`define ORDF_TICK_CYC      (`ORDF_TICK_NS / `ORDF_CLK_NS)
`define ORDF_T_DEF_CS      32'h0000_0003
`define ORDF_T_MAX_CS      32'h0000_7530
`endif

// ---- src/ordf_timer.sv ----
`timescale 1ns/1ps
`include "ordf_regs.svh"
module ordf_timer
  import ordf_pkg::*;
#(
  parameter int TICK_CYC = `ORDF_TICK_CYC
) (
  input  wire logic     clk,
  input  wire logic     rst,
  input  wire logic     start,
  input  wire logic     stop,
  input  wire ordf_cs_t load,
  output logic          expired
);
  logic [31:0] pre_q, pre_d;
  ordf_cs_t    cnt_q, cnt_d;
  logic        run_q, run_d, exp_d;
  // Centisecond ticks; zero delay raises expired two cycles after start
  always_comb begin
    pre_d = pre_q;
    cnt_d = cnt_q;
    run_d = run_q;
    exp_d = 1'b0;
    // Start beats stop: the stop term is still true on the start cycle
    if (start) begin
      run_d = 1'b1;
      cnt_d = load;
      pre_d = 32'h0;
    end else if (stop) begin
      run_d = 1'b0;
    end else if (run_q) begin
      if (cnt_q == 16'h0) begin
        run_d = 1'b0;
        exp_d = 1'b1;
      end else if (pre_q == 32'(TICK_CYC - 1)) begin
        pre_d = 32'h0;
        cnt_d = cnt_q - 16'h1;
      end else begin
        pre_d = pre_q + 32'h1;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      pre_q   <= 32'h0;
      cnt_q   <= 16'h0;
      run_q   <= 1'b0;
      expired <= 1'b0;
    end else begin
      pre_q   <= pre_d;
      cnt_q   <= cnt_d;
      run_q   <= run_d;
      expired <= exp_d;
    end
  end
endmodule : ordf_timer

// ---- src/ordf_top.sv ----
// Functional notes
// - Optional inversion of seventh input, default off
// - Disarm-enable setting, inactive by default
// - Permanent or timeout disarm, permanent default
// - Supervision contact never disarmed
// - Timeout disarm re-arms after programmable delay
// - Force ignored while disarmed
// - Force to energized or de-energized
// - Permanent or timed force, permanent default
// - Timed force holds state for delay
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "ordf_regs.svh"
module ordf_top
  import ordf_pkg::*;
#(
  parameter int NREL     = 4,
  parameter int NIN      = 7,
  parameter int TICK_CYC = `ORDF_TICK_CYC
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic [NREL*NIN-1:0] sig_in,
  input  wire logic                 sup_in,
  output logic [NREL-1:0]          relay_out,
  output logic                      sup_out,
  input  wire logic [11:0]          s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [11:0]          s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready
);
  logic [NREL*NIN-1:0] s1_q, s2_q;
  logic        sup1_q, sup2_q;
  logic [31:0] ctrl_q, ctrl_d, inv_q, inv_d, rd_data;
  ordf_cs_t    tdis_q, tdis_d, tfrc_q, tfrc_d;
  logic        dis_cmd_q, dis_cmd_d;
  ordf_force_e frc_q, frc_d;
  logic        wr_en, rd_ok, wr_ok, dis_exp, frc_exp, dis_start, frc_start;
  logic [11:0] wr_addr, rd_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        disarmed;
  logic [NREL-1:0] rel_d;

  function automatic ordf_cs_t clip_cs(input logic [31:0] v);
    // Keep delays inside 0.00 to 300.00 s
    clip_cs = (v > `ORDF_T_MAX_CS) ? 16'(`ORDF_T_MAX_CS) : v[15:0];
  endfunction : clip_cs

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      merge[b*8 +: 8] = s[b] ? n[b*8 +: 8] : o[b*8 +: 8];
    end
  endfunction : merge

  ordf_axil u_bus (
    .clk(clk), .rst(rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .wr_strb(wr_strb),
    .rd_addr(rd_addr), .rd_data(rd_data), .rd_ok(rd_ok), .wr_ok(wr_ok)
  );

  ordf_timer #(.TICK_CYC(TICK_CYC)) u_tdis (
    .clk(clk), .rst(rst), .start(dis_start), .stop(!disarmed || !ctrl_q[`ORDF_CTRL_DIS_TMO]),
    .load(tdis_q), .expired(dis_exp)
  );

  ordf_timer #(.TICK_CYC(TICK_CYC)) u_tfrc (
    .clk(clk), .rst(rst), .start(frc_start), .stop(frc_q == ORDF_NORMAL),
    .load(tfrc_q), .expired(frc_exp)
  );

  assign disarmed = ctrl_q[`ORDF_CTRL_DIS_EN] && dis_cmd_q;

  always_comb begin
    wr_ok = 1'b1;
    unique case (wr_addr)
      `ORDF_CTRL_OFF, `ORDF_CMD_OFF, `ORDF_TDIS_OFF, `ORDF_TFRC_OFF, `ORDF_INV_OFF: ;
      `ORDF_STAT_OFF: ;
      default: wr_ok = 1'b0;
    endcase
  end

  always_comb begin
    rd_ok = 1'b1;
    rd_data = 32'h0;
    unique case (rd_addr)
      `ORDF_CTRL_OFF: rd_data = ctrl_q;
      `ORDF_CMD_OFF: rd_data = 32'h0;
      `ORDF_TDIS_OFF: rd_data = {16'h0, tdis_q};
      `ORDF_TFRC_OFF: rd_data = {16'h0, tfrc_q};
      `ORDF_INV_OFF: rd_data = inv_q;
      `ORDF_STAT_OFF: rd_data = {20'h0, sup_out, disarmed, frc_q, 4'h0, 4'(relay_out)};
      default: rd_ok = 1'b0;
    endcase
  end

  // Settings and commands
  always_comb begin
    ctrl_d = ctrl_q;
    inv_d = inv_q;
    tdis_d = tdis_q;
    tfrc_d = tfrc_q;
    dis_cmd_d = dis_cmd_q;
    frc_d = frc_q;
    dis_start = 1'b0;
    frc_start = 1'b0;
    if (!ctrl_q[`ORDF_CTRL_DIS_EN]) begin
      dis_cmd_d = 1'b0;
    end
    if (dis_exp) begin
      dis_cmd_d = 1'b0;
    end
    if (frc_exp) begin
      frc_d = ORDF_NORMAL;
    end
    if (disarmed) begin
      frc_d = ORDF_NORMAL;
    end
    if (wr_en) begin
      unique case (wr_addr)
        `ORDF_CTRL_OFF: ctrl_d = merge(ctrl_q, wr_data, wr_strb) & 32'h7;
        `ORDF_TDIS_OFF: tdis_d = clip_cs(merge({16'h0, tdis_q}, wr_data, wr_strb));
        `ORDF_TFRC_OFF: tfrc_d = clip_cs(merge({16'h0, tfrc_q}, wr_data, wr_strb));
        `ORDF_INV_OFF: inv_d = merge(inv_q, wr_data, wr_strb);
        `ORDF_CMD_OFF: begin
          if (wr_strb[0] && wr_data[`ORDF_CMD_DISARM] && ctrl_q[`ORDF_CTRL_DIS_EN]) begin
            dis_cmd_d = 1'b1;
            dis_start = ctrl_q[`ORDF_CTRL_DIS_TMO];
            frc_d = ORDF_NORMAL;
          end else if (wr_strb[0] && wr_data[`ORDF_CMD_REARM]) begin
            dis_cmd_d = 1'b0;
          end else if (wr_strb[0] && !disarmed) begin
            if (wr_data[`ORDF_CMD_FRC_ON]) begin
              frc_d = ORDF_FRC_ON;
              frc_start = ctrl_q[`ORDF_CTRL_FRC_TMO];
            end else if (wr_data[`ORDF_CMD_FRC_OFF]) begin
              frc_d = ORDF_FRC_OFF;
              frc_start = ctrl_q[`ORDF_CTRL_FRC_TMO];
            end else if (wr_data[`ORDF_CMD_FRC_CLR]) begin
              frc_d = ORDF_NORMAL;
            end
          end
        end
        default: ;
      endcase
    end
  end

  // Combination is an OR of possibly inverted inputs
  always_comb begin
    for (int r = 0; r < NREL; r++) begin
      rel_d[r] = 1'b0;
      for (int i = 0; i < NIN; i++) begin
        rel_d[r] = rel_d[r] | (s2_q[r*NIN+i] ^ inv_q[(r*NIN+i) % 32]);
      end
      if (disarmed) begin
        rel_d[r] = 1'b0;
      end else if (frc_q == ORDF_FRC_ON) begin
        rel_d[r] = 1'b1;
      end else if (frc_q == ORDF_FRC_OFF) begin
        rel_d[r] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      sup1_q <= 1'b0;
      sup2_q <= 1'b0;
      ctrl_q <= `ORDF_CTRL_RST;
      inv_q <= `ORDF_INV_RST;
      tdis_q <= 16'(`ORDF_T_DEF_CS);
      tfrc_q <= 16'(`ORDF_T_DEF_CS);
      dis_cmd_q <= 1'b0;
      frc_q <= ORDF_NORMAL;
      relay_out <= '0;
      sup_out <= 1'b0;
    end else begin
      s1_q <= sig_in;
      s2_q <= s1_q;
      sup1_q <= sup_in;
      sup2_q <= sup1_q;
      ctrl_q <= ctrl_d;
      inv_q <= inv_d;
      tdis_q <= tdis_d;
      tfrc_q <= tfrc_d;
      dis_cmd_q <= dis_cmd_d;
      frc_q <= frc_d;
      relay_out <= rel_d;
      // Supervision contact bypasses disarm and force
      sup_out <= sup2_q;
    end
  end
endmodule : ordf_top
